//--- mfc_pkg.sv
// Constants shared by the message file command unit
package mfc_pkg;
  // ==========================================================
  // Register indices on the plain register port
  localparam logic [2:0] REG_CMD    = 3'h0;
  localparam logic [2:0] REG_CTL    = 3'h1;
  localparam logic [2:0] REG_DATA   = 3'h2;
  localparam logic [2:0] REG_POS    = 3'h3;
  localparam logic [2:0] REG_ENC    = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam logic [2:0] REG_OPEN   = 3'h6;
  // ==========================================================
  // Field positions
  localparam int CMD_W       = 5;   // Command code width
  localparam int CMD_REMAP   = 5;   // Remap option bit
  localparam int CMD_ABORT   = 7;   // Abort request bit
  localparam int FNO_W       = 8;   // File number width
  localparam int CTL_MS      = 8;   // Memory space bit
  localparam int CTL_MD      = 9;   // Access mode bit (1 = binary)
  localparam int RATE_W      = 2;   // Target rate field width
  localparam int ST_BUSY     = 0;   // Busy status bit
  localparam int ST_ERR      = 1;   // Error status bit
  localparam int ST_PEND     = 2;   // Recompression pending bit
  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0]  RST_RATE = 2'h0;
  localparam logic [7:0]  RST_FNO  = 8'h00;
  // ==========================================================
  // Command codes
  localparam logic [4:0] C_OPEN    = 5'h01;
  localparam logic [4:0] C_SEEK    = 5'h02;
  localparam logic [4:0] C_DELM    = 5'h03;
  localparam logic [4:0] C_CMP     = 5'h04;
  localparam logic [4:0] C_MSTAT   = 5'h05;
  localparam logic [4:0] C_GC      = 5'h06;
  localparam logic [4:0] C_WR_TS   = 5'h07;
  localparam logic [4:0] C_WR_USR  = 5'h08;
  localparam logic [4:0] C_RD_USR  = 5'h09;
  localparam logic [4:0] C_RD_TS1  = 5'h0a;
  localparam logic [4:0] C_RD_TS2  = 5'h0b;
  localparam logic [4:0] C_RD_LEN  = 5'h0c;
  localparam logic [4:0] C_RD_DAT  = 5'h0d;
  localparam logic [4:0] C_WR_DAT  = 5'h0e;
  // ==========================================================
  // Memory sizing
  localparam int NFILES   = 16;     // Descriptor slots incl. file 0
  localparam int FWORDS   = 64;     // Data words per file slot
  localparam int BLK_SLOT = 1;      // 1 kByte blocks per file slot
endpackage

//--- mfc_data_mem.sv
// File data store with synchronous read and write
`timescale 1ns/1ps
module mfc_data_mem import mfc_pkg::*; #(
  parameter int AW = 10,
  parameter int DW = 16
) (
  // Clock
  input  wire logic          mclk,
  // Access port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  // Word array
  logic [DW-1:0] mem [2**AW];

  // Write port
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge mclk) begin
    rdata <= mem[addr];
  end
endmodule // mfc_data_mem

//--- mfc_cmd_unit.sv
// Command unit of the message file system
// Notes on behaviour
// - Delete-multiple marks files from number upward
// - Marked files keep resources until collection
// - Compress lowers rate to encoder field value
// - Compress abortable, resumable, frees only later
// - Compress starts at position register offset
// - Compress errors: bad file, open, binary
// - Memory status returns free 1k blocks
// - Collection releases all marked files
// - Remap renumbers survivors contiguously from one
// - Collection uses r/w directory, needs closed
// - Collection reissuable, refused while compress pending
// - Descriptor commands never touch file content
// - Timestamp write stores data, position; closed
// - User write needs open file
// - Four descriptor reads into data register
// - Binary read returns word, advances pointer
// - Binary write stores word, advances pointer
// - Binary write errors: range, prompt, full, audio
// - Error flag cleared on success, set on error
// - Seek loads open file pointer
`timescale 1ns/1ps
module mfc_cmd_unit import mfc_pkg::*; #(
  parameter int NF = NFILES,
  parameter int FW = FWORDS,
  parameter int BK = BLK_SLOT
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Status
  output logic             busy
);
  // ==========================================================
  // Local sizes
  localparam int IW = $clog2(NF);        // File index width
  localparam int PW = $clog2(FW);        // Word offset width
  localparam int AW = IW + PW;           // Data address width
  localparam logic [15:0] FW16 = 16'(FW); // Slot capacity

  typedef enum logic [2:0] {
    S_IDLE, S_DELM, S_CMP, S_GC, S_RDA, S_RDW, S_DONE
  } mfc_state_e;

  // ==========================================================
  // Host registers
  logic [CMD_W-1:0] cmd_r;      // Last command code
  logic             remap_r;    // Remap option
  logic [FNO_W-1:0] fno_r;      // File number parameter
  logic             ms_r;       // Memory space, 1 = prompt
  logic             md_r;       // Access mode, 1 = binary
  logic [15:0]      data_r;     // Data register
  logic [15:0]      pos_r;      // Position register
  logic [RATE_W-1:0] rate_r;    // Target rate field
  logic             err_r;      // Error flag
  logic             res_we_r;   // Result load strobe
  logic [15:0]      res_r;      // Result word
  mfc_state_e       st_r;       // Sequencer state

  // Directory
  logic          d_vld  [NF];   // Descriptor in use
  logic          d_del  [NF];   // Marked for deletion
  logic          d_bin  [NF];   // Binary file
  logic [1:0]    d_rate [NF];   // Current bit rate
  logic [15:0]   d_user [NF];   // User data entry
  logic [15:0]   d_ts1  [NF];   // First timestamp
  logic [15:0]   d_ts2  [NF];   // Second timestamp
  logic [15:0]   d_len  [NF];   // Length in words
  logic [IW-1:0] d_slot [NF];   // Data slot owned
  logic [NF-1:0] slot_used_r;   // Slots taken

  // Open file and sequencing state
  logic [IW-1:0] open_r;        // Open file, 0 = none
  logic          open_ms_r;     // Open in prompt space
  logic [15:0]   fp_r;          // Pointer of open file
  logic [IW-1:0] ix_r;          // Scan index
  logic [IW-1:0] dst_r;         // Remap destination
  logic          cpend_r;       // Recompression pending
  logic [IW-1:0] cfile_r;       // Pending file
  logic [15:0]   cpos_r;        // Recompression position
  logic [1:0]    ctgt_r;        // Recompression target

  // Data store port
  logic          m_we_r;        // Write strobe
  logic [AW-1:0] m_addr_r;      // Address
  logic [15:0]   m_wd_r;        // Write word
  logic [15:0]   m_q;           // Read word

  // Decoded host strobes
  logic go;                     // New command accepted
  logic abort;                  // Abort request
  logic cmd_hit;                // Write to command register
  logic [IW-1:0] fsel;          // Parameter file index
  logic          fno_in;        // Parameter within directory

  // ==========================================================
  // Helper functions
  // File holds a live descriptor
  function automatic logic live(input logic [IW-1:0] f);
    live = (f != '0) && d_vld[f] && !d_del[f];
  endfunction

  // Lowest free data slot
  function automatic logic [IW:0] free_slot(input logic [NF-1:0] u);
    free_slot = {1'b0, {IW{1'b0}}};
    for (int i = NF - 1; i >= 0; i--) begin
      if (!u[i]) begin
        free_slot = {1'b1, IW'(i)};
      end
    end
  endfunction

  // Number of free slots
  function automatic logic [15:0] free_cnt(input logic [NF-1:0] u);
    free_cnt = 16'h0000;
    for (int i = 0; i < NF; i++) begin
      free_cnt = free_cnt + {15'h0000, !u[i]};
    end
  endfunction

  assign cmd_hit = reg_wr && (reg_addr == REG_CMD);
  assign abort   = cmd_hit && reg_wdata[CMD_ABORT];
  assign go      = cmd_hit && !reg_wdata[CMD_ABORT] && (st_r == S_IDLE);
  assign busy    = (st_r != S_IDLE);
  assign fsel    = fno_r[IW-1:0];
  assign fno_in  = (fno_r < FNO_W'(NF));

  // ==========================================================
  // Host register writes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd_r   <= '0;
      remap_r <= 1'b0;
      fno_r   <= RST_FNO;
      ms_r    <= 1'b0;
      md_r    <= 1'b0;
      pos_r   <= RST_WORD;
      rate_r  <= RST_RATE;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_CMD: begin
          if (go) begin
            cmd_r   <= reg_wdata[CMD_W-1:0];
            remap_r <= reg_wdata[CMD_REMAP];
          end
        end
        REG_CTL: begin
          fno_r <= reg_wdata[FNO_W-1:0];
          ms_r  <= reg_wdata[CTL_MS];
          md_r  <= reg_wdata[CTL_MD];
        end
        REG_POS: pos_r  <= reg_wdata;
        REG_ENC: rate_r <= reg_wdata[RATE_W-1:0];
        default: ;
      endcase
    end
  end

  // Data register, result wins over host write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_r <= RST_WORD;
    end else if (res_we_r) begin
      data_r <= res_r;
    end else if (reg_wr && reg_addr == REG_DATA) begin
      data_r <= reg_wdata;
    end
  end

  // Read data one cycle after strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_CMD:    reg_rdata <= {10'h000, remap_r, cmd_r};
        REG_CTL:    reg_rdata <= {6'h00, md_r, ms_r, fno_r};
        REG_DATA:   reg_rdata <= data_r;
        REG_POS:    reg_rdata <= pos_r;
        REG_ENC:    reg_rdata <= {14'h0000, rate_r};
        REG_STATUS: reg_rdata <= {13'h0000, cpend_r, err_r, busy};
        REG_OPEN:   reg_rdata <= {{(16 - IW){1'b0}}, open_r};
        default:    reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // Command sequencer and directory
  always_ff @(posedge mclk) begin
    logic [IW:0]   fs;
    logic [IW-1:0] tf;
    fs = free_slot(slot_used_r);
    tf = (open_r != '0) ? open_r : fsel;
    if (!rst_n) begin
      st_r <= S_IDLE;
      err_r <= 1'b0;
      res_we_r <= 1'b0;
      res_r <= RST_WORD;
      open_r <= '0;
      open_ms_r <= 1'b0;
      fp_r <= RST_WORD;
      ix_r <= '0;
      dst_r <= '0;
      cpend_r <= 1'b0;
      cfile_r <= '0;
      cpos_r <= RST_WORD;
      ctgt_r <= RST_RATE;
      m_we_r <= 1'b0;
      m_addr_r <= '0;
      m_wd_r <= RST_WORD;
      slot_used_r <= '0;
      for (int i = 0; i < NF; i++) begin
        d_vld[i] <= 1'b0;
        d_del[i] <= 1'b0;
        d_bin[i] <= 1'b0;
        d_rate[i] <= RST_RATE;
        d_user[i] <= RST_WORD;
        d_ts1[i] <= RST_WORD;
        d_ts2[i] <= RST_WORD;
        d_len[i] <= RST_WORD;
        d_slot[i] <= '0;
      end
    end else begin
      res_we_r <= 1'b0;
      m_we_r <= 1'b0;
      unique case (st_r)
        S_IDLE: begin
          if (go) begin
            err_r <= 1'b0;
            st_r <= S_DONE;
            unique case (reg_wdata[CMD_W-1:0])
              C_OPEN: begin
                if (fno_r == '0) begin
                  open_r <= '0;
                end else if (!fno_in || d_del[fsel]) begin
                  err_r <= 1'b1;
                end else if (d_vld[fsel]) begin
                  if (d_bin[fsel] != md_r || (cpend_r && cfile_r == fsel)) begin
                    err_r <= 1'b1;
                  end else begin
                    open_r <= fsel;
                    open_ms_r <= ms_r;
                    fp_r <= RST_WORD;
                  end
                end else if (ms_r || !fs[IW]) begin
                  err_r <= 1'b1;
                end else begin
                  d_vld[fsel] <= 1'b1;
                  d_bin[fsel] <= md_r;
                  d_rate[fsel] <= rate_r;
                  d_len[fsel] <= RST_WORD;
                  d_slot[fsel] <= fs[IW-1:0];
                  slot_used_r[fs[IW-1:0]] <= 1'b1;
                  open_r <= fsel;
                  open_ms_r <= 1'b0;
                  fp_r <= RST_WORD;
                end
              end
              C_SEEK: begin
                if (open_r == '0 || pos_r > d_len[open_r]) begin
                  err_r <= 1'b1;
                end else begin
                  fp_r <= pos_r;
                end
              end
              C_DELM: begin
                if (open_r != '0 || fno_r == '0) begin
                  err_r <= 1'b1;
                end else if (fno_in) begin
                  ix_r <= fsel;
                  st_r <= S_DELM;
                end
              end
              C_CMP: begin
                if (open_r != '0 || !fno_in || !live(fsel) || d_bin[fsel] ||
                    rate_r >= d_rate[fsel] || (cpend_r && cfile_r != fsel)) begin
                  err_r <= 1'b1;
                end else begin
                  cpend_r <= 1'b1;
                  cfile_r <= fsel;
                  ctgt_r <= rate_r;
                  // Resume keeps the saved position
                  cpos_r <= cpend_r ? cpos_r : pos_r;
                  st_r <= S_CMP;
                end
              end
              C_MSTAT: begin
                if (open_r != '0) begin
                  err_r <= 1'b1;
                end else begin
                  res_r <= 16'(free_cnt(slot_used_r) * BK);
                  res_we_r <= 1'b1;
                end
              end
              C_GC: begin
                if (open_r != '0 || cpend_r) begin
                  err_r <= 1'b1;
                end else begin
                  ix_r <= IW'(1);
                  dst_r <= IW'(1);
                  st_r <= S_GC;
                end
              end
              C_WR_TS: begin
                if (open_r != '0 || !fno_in || !live(fsel)) begin
                  err_r <= 1'b1;
                end else begin
                  d_ts1[fsel] <= data_r;
                  d_ts2[fsel] <= pos_r;
                end
              end
              C_WR_USR: begin
                if (open_r == '0) begin
                  err_r <= 1'b1;
                end else begin
                  d_user[open_r] <= data_r;
                end
              end
              C_RD_USR, C_RD_TS1, C_RD_TS2, C_RD_LEN: begin
                if (open_r == '0 && (!fno_in || !d_vld[fsel] || fsel == '0)) begin
                  err_r <= 1'b1;
                end else begin
                  res_we_r <= 1'b1;
                  unique case (reg_wdata[CMD_W-1:0])
                    C_RD_USR: res_r <= d_user[tf];
                    C_RD_TS1: res_r <= d_ts1[tf];
                    C_RD_TS2: res_r <= d_ts2[tf];
                    default:  res_r <= d_len[tf];
                  endcase
                end
              end
              C_RD_DAT: begin
                if (open_r == '0 || !d_bin[open_r] || fp_r >= d_len[open_r]) begin
                  err_r <= 1'b1;
                end else begin
                  m_addr_r <= {d_slot[open_r], fp_r[PW-1:0]};
                  st_r <= S_RDA;
                end
              end
              C_WR_DAT: begin
                if (open_r == '0 || !d_bin[open_r] || open_ms_r ||
                    fp_r > d_len[open_r] || fp_r >= FW16) begin
                  err_r <= 1'b1;
                end else begin
                  m_we_r <= 1'b1;
                  m_addr_r <= {d_slot[open_r], fp_r[PW-1:0]};
                  m_wd_r <= data_r;
                  fp_r <= fp_r + 16'h0001;
                  if (fp_r == d_len[open_r]) begin
                    d_len[open_r] <= fp_r + 16'h0001;
                  end
                end
              end
              default: err_r <= 1'b1;
            endcase
          end
        end
        S_DELM: begin
          // Mark only; slot and descriptor stay held
          if (d_vld[ix_r]) begin
            d_del[ix_r] <= 1'b1;
          end
          ix_r <= ix_r + IW'(1);
          if (abort || ix_r == IW'(NF - 1)) begin
            st_r <= S_DONE;
          end
        end
        S_CMP: begin
          // One unit re-encoded per cycle
          if (abort) begin
            st_r <= S_DONE;
          end else if (cpos_r >= d_len[cfile_r]) begin
            d_rate[cfile_r] <= ctgt_r;
            cpend_r <= 1'b0;
            cpos_r <= RST_WORD;
            st_r <= S_DONE;
          end else begin
            cpos_r <= cpos_r + 16'h0001;
          end
        end
        S_GC: begin
          // Scan r/w directory, release or compact
          if (d_vld[ix_r] && d_del[ix_r]) begin
            d_vld[ix_r] <= 1'b0;
            d_del[ix_r] <= 1'b0;
            slot_used_r[d_slot[ix_r]] <= 1'b0;
          end else if (d_vld[ix_r] && remap_r) begin
            dst_r <= dst_r + IW'(1);
            if (dst_r != ix_r) begin
              d_vld[dst_r] <= 1'b1;
              d_del[dst_r] <= 1'b0;
              d_bin[dst_r] <= d_bin[ix_r];
              d_rate[dst_r] <= d_rate[ix_r];
              d_user[dst_r] <= d_user[ix_r];
              d_ts1[dst_r] <= d_ts1[ix_r];
              d_ts2[dst_r] <= d_ts2[ix_r];
              d_len[dst_r] <= d_len[ix_r];
              d_slot[dst_r] <= d_slot[ix_r];
              d_vld[ix_r] <= 1'b0;
            end
          end
          ix_r <= ix_r + IW'(1);
          // Abort is safe; reissue finishes the job
          if (abort || ix_r == IW'(NF - 1)) begin
            st_r <= S_DONE;
          end
        end
        S_RDA: st_r <= S_RDW;
        S_RDW: begin
          res_r <= m_q;
          res_we_r <= 1'b1;
          fp_r <= fp_r + 16'h0001;
          st_r <= S_DONE;
        end
        S_DONE: st_r <= S_IDLE;
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // File data store
  mfc_data_mem #(
    .AW (AW),
    .DW (16)
  ) u_mem (
    .mclk  (mclk),
    .we    (m_we_r),
    .addr  (m_addr_r),
    .wdata (m_wd_r),
    .rdata (m_q)
  );
endmodule // mfc_cmd_unit

//--- mfc_cmd_unit_properties.sv
// Port-level checker for the message file command unit
`timescale 1ns/1ps
module mfc_cmd_unit_chk import mfc_pkg::*; (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Register port
  input wire logic [2:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Status
  input wire logic        busy
);
  // ==========================================================
  // Helpers
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic take; // Known code written while idle
  assign take = reg_wr && reg_addr == REG_CMD && !reg_wdata[CMD_ABORT] && !busy &&
                reg_wdata[4:0] >= C_OPEN && reg_wdata[4:0] <= C_WR_DAT;
  // ==========================================================
  // Properties
  property p_take_busy; take |=> busy; endproperty
  a_take_busy: assert property (p_take_busy) else $error("busy missing");
  property p_rise_cause; $rose(busy) |-> $past(reg_wr) && $past(reg_addr) == REG_CMD;
  endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("busy without command");
  property p_done; take |=> busy ##[1:80] !busy; endproperty
  a_done: assert property (p_done) else $error("command never ends");
  property p_quick; take && reg_wdata[4:0] == C_MSTAT |=> busy ##[1:3] !busy; endproperty
  a_quick: assert property (p_quick) else $error("status command too long");
  property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmapped; reg_rd && reg_addr == 3'h7 |=> reg_rdata == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_stat_busy; reg_rd && reg_addr == REG_STATUS |=> reg_rdata[ST_BUSY] == $past(busy);
  endproperty
  a_stat_busy: assert property (p_stat_busy) else $error("status busy wrong");
  property p_enc_back;
    reg_wr && reg_addr == REG_ENC ##2 reg_rd && reg_addr == REG_ENC
      |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 3);
  endproperty
  a_enc_back: assert property (p_enc_back) else $error("rate field lost");
  // Main scenarios
  c_remap: cover property (take && reg_wdata[4:0] == C_GC && reg_wdata[CMD_REMAP]);
  c_read: cover property (take && reg_wdata[4:0] == C_RD_DAT);
  c_end: cover property ($fell(busy));
endmodule // mfc_cmd_unit_chk
bind mfc_cmd_unit mfc_cmd_unit_chk u_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy));

//--- mfc_host_model.sv
// Host microcontroller model driving the register port
`timescale 1ns/1ps
module mfc_host_model import mfc_pkg::*; (
  // Clock and status
  input  wire logic   mclk,
  input  wire logic   busy,
  // Register port
  output logic [2:0]  reg_addr,
  output logic [15:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd
);
  // Idle bus at time zero
  initial begin
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write cycle; lines scrambled once released
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // One read cycle; data stand in the next cycle
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask
  // Code written last, then wait idle before results
  task automatic cmd(input logic [15:0] c);
    wr(REG_CMD, c);
    for (int i = 0; i < 200; i++) begin
      @(negedge mclk);
      if (!busy) break;
    end
  endtask
endmodule // mfc_host_model

//--- mfc_cmd_unit_bench.sv
// Self-checking bench for the message file command unit
`timescale 1ns/1ps
module mfc_cmd_unit_bench import mfc_pkg::*;;
  typedef struct {logic [15:0] val; logic [15:0] msk;} mfc_exp_s;
  logic        mclk, rst_n, reg_wr, reg_rd, busy;
  logic        rd_d = 1'b0;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [15:0] w[6];
  int          bad_count, num_checks;
  mfc_exp_s    expq[$];
  // Clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  mfc_cmd_unit dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy));
  mfc_host_model host (.mclk(mclk), .busy(busy), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  // Monitor: compare read slot with oldest note
  always @(posedge mclk) rd_d <= reg_rd;
  always @(negedge mclk) begin
    if (rd_d === 1'b1) begin
      mfc_exp_s e;
      e = expq.pop_front();
      num_checks++;
      if ((reg_rdata & e.msk) !== e.val) begin
        bad_count++;
        $display("BAD %0t read %h want %h", $time, reg_rdata, e.val);
      end
    end
  end
  // Note expectation, then read
  task automatic chk(input logic [2:0] a, input logic [15:0] v, input logic [15:0] m);
    expq.push_back('{v, m});
    host.rd(a);
  endtask
  // Command, then busy and error bits
  task automatic run(input logic [4:0] c, input logic e);
    host.cmd({11'h000, c});
    chk(REG_STATUS, {14'h0000, e, 1'b0}, 16'h0003);
  endtask
  // Binary file of n words in write space
  task automatic mk(input logic [7:0] f, input int n);
    host.wr(REG_CTL, {8'h02, f});
    run(C_OPEN, 1'b0);
    for (int i = 0; i < n; i++) begin
      host.wr(REG_DATA, 16'($urandom));
      run(C_WR_DAT, 1'b0);
    end
    host.wr(REG_CTL, 16'h0000);
    run(C_OPEN, 1'b0);
  endtask
  // Verdict
  task automatic finish_test;
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog
  initial begin
    #3000000;
    bad_count++;
    finish_test;
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    void'($urandom(97860));
    for (int i = 0; i < 6; i++) w[i] = 16'($urandom);
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) chk(3'(a), 16'h0000, 16'hffff);
    host.wr(REG_ENC, w[5]);
    chk(REG_ENC, {14'h0000, w[5][1:0]}, 16'h0003);
    // Binary file 1: write three words, read back
    host.wr(REG_CTL, 16'h0201);
    run(C_OPEN, 1'b0);
    chk(REG_OPEN, 16'h0001, 16'hffff);
    host.wr(REG_POS, 16'h0000);
    run(C_SEEK, 1'b0);
    for (int i = 0; i < 3; i++) begin
      host.wr(REG_DATA, w[i]);
      run(C_WR_DAT, 1'b0);
    end
    run(C_SEEK, 1'b0);
    for (int i = 0; i < 3; i++) begin
      run(C_RD_DAT, 1'b0);
      chk(REG_DATA, w[i], 16'hffff);
    end
    run(C_RD_DAT, 1'b1);
    run(C_RD_LEN, 1'b0);
    chk(REG_DATA, 16'h0003, 16'hffff);
    host.wr(REG_DATA, w[3]);
    run(C_WR_USR, 1'b0);
    host.wr(REG_DATA, ~w[3]);
    run(C_RD_USR, 1'b0);
    chk(REG_DATA, w[3], 16'hffff);
    // Refusals while a file is open, then user write refused once closed
    foreach (w[i]) if (i < 5) run(5'(C_DELM + i), 1'b1);
    host.wr(REG_CTL, 16'h0000);
    run(C_OPEN, 1'b0);
    run(C_WR_USR, 1'b1);
    // Timestamps on closed file 1
    host.wr(REG_CTL, 16'h0001);
    host.wr(REG_DATA, w[4]);
    host.wr(REG_POS, w[5]);
    run(C_WR_TS, 1'b0);
    host.wr(REG_DATA, 16'h0000);
    run(C_RD_TS1, 1'b0);
    chk(REG_DATA, w[4], 16'hffff);
    run(C_RD_TS2, 1'b0);
    chk(REG_DATA, w[5], 16'hffff);
    run(C_CMP, 1'b1);
    // File content untouched by descriptor writes
    host.wr(REG_CTL, 16'h0201);
    run(C_OPEN, 1'b0);
    host.wr(REG_POS, 16'h0000);
    run(C_SEEK, 1'b0);
    run(C_RD_DAT, 1'b0);
    chk(REG_DATA, w[0], 16'hffff);
    host.wr(REG_CTL, 16'h0000);
    run(C_OPEN, 1'b0);
    run(C_CMP, 1'b1);
    run(C_DELM, 1'b1);
    // Delete, collect, remap
    mk(8'h02, 1);
    mk(8'h03, 1);
    host.wr(REG_CTL, 16'h0002);
    run(C_DELM, 1'b0);
    run(C_MSTAT, 1'b0);
    chk(REG_DATA, 16'((NFILES - 3) * BLK_SLOT), 16'hffff);
    run(C_RD_LEN, 1'b0);
    chk(REG_DATA, 16'h0001, 16'hffff);
    run(C_GC, 1'b0);
    run(C_MSTAT, 1'b0);
    chk(REG_DATA, 16'((NFILES - 1) * BLK_SLOT), 16'hffff);
    run(C_RD_LEN, 1'b1);
    mk(8'h03, 2);
    host.cmd({10'h000, 1'b1, C_GC});
    chk(REG_STATUS, 16'h0000, 16'h0003);
    host.wr(REG_CTL, 16'h0002);
    run(C_RD_LEN, 1'b0);
    chk(REG_DATA, 16'h0002, 16'hffff);
    host.wr(REG_CTL, 16'h0003);
    run(C_RD_LEN, 1'b1);
    // Audio file 4: compress to a lower rate, then collect
    host.wr(REG_ENC, 16'h0003);
    host.wr(REG_CTL, 16'h0004);
    run(C_OPEN, 1'b0);
    host.wr(REG_CTL, 16'h0000);
    run(C_OPEN, 1'b0);
    host.wr(REG_CTL, 16'h0004);
    host.wr(REG_ENC, 16'h0001);
    run(C_CMP, 1'b0);
    run(C_CMP, 1'b1);
    run(C_GC, 1'b0);
    repeat (3) @(posedge mclk);
    finish_test;
  end
endmodule // mfc_cmd_unit_bench
